// ### src/ucf_regs.svh
`ifndef UCF_REGS_SVH
`define UCF_REGS_SVH
// Register byte offsets on the Avalon-MM slave.
`define UCF_OFF_MODE      5'h00
`define UCF_OFF_STATUS    5'h04
`define UCF_OFF_RXDATA    5'h08
`define UCF_OFF_CMD       5'h0C
`define UCF_OFF_OUTPORT   5'h10
`define UCF_OFF_ZEROMODE  5'h14
`define UCF_OFF_TXDATA    5'h18
// Command codes written to the command register.
`define UCF_CMD_SET_PTR   8'h01
`define UCF_CMD_RST_ERR   8'h02
// Field positions in the format mode register.
`define UCF_F_FLOW_EN     7
`define UCF_F_LVL_LO      6
`define UCF_F_ERRMODE     5
`define UCF_F_PMODE_HI    4
`define UCF_F_PMODE_LO    3
`define UCF_F_PTYPE       2
`define UCF_F_LEN_HI      1
`define UCF_F_LEN_LO      0
// Field positions in the zero mode register and output port register.
`define UCF_F_LVL_HI      6
`define UCF_F_DEPTH_SEL   3
`define UCF_F_RTS_BIT     0
// Parity mode encodings.
`define UCF_PM_WITH       2'h0
`define UCF_PM_FORCE      2'h1
`define UCF_PM_NONE       2'h2
`define UCF_PM_MDROP      2'h3
// Reset values, depths and the default bit time.
`define UCF_RST_BYTE      8'h00
`define UCF_DEPTH_SMALL   5'h08
`define UCF_DEPTH_LARGE   5'h10
`define UCF_BIT_CYCLES    16
`endif

// ### src/ucf_pkg.sv
`default_nettype none
package ucf_pkg;
  // Receiver and transmitter sequencer states.
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucf_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucf_tx_e;
  // One received character with its status.
  typedef struct packed {
    logic       brk;
    logic       parity_err;
    logic       frame_err;
    logic [7:0] data;
  } ucf_entry_s;
  // Complete state of the channel except the receive FIFO.
  typedef struct packed {
    logic [7:0]  format_mode;
    logic [7:0]  line_mode;
    logic [7:0]  zero_mode;
    logic [7:0]  out_port;
    logic        ptr_second;
    logic        wait_req;
    logic        rd_ok;
    logic [31:0] rdata;
    logic        rts_n;
    logic        flow_neg;
    logic        level;
    logic        rx_s1;
    logic        rx_s2;
    ucf_rx_e     rx_st;
    logic [15:0] rx_cnt;
    logic [2:0]  rx_bit;
    logic [7:0]  rx_shift;
    logic        rx_par;
    logic        valid_start;
    logic        hold_v;
    ucf_entry_s  hold;
    logic        drop_cur;
    logic        overrun;
    logic [2:0]  accum;
    ucf_tx_e     tx_st;
    logic [15:0] tx_cnt;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_shift;
    logic        tx_par;
    logic        txd;
  } ucf_state_s;
endpackage : ucf_pkg
`default_nettype wire

// ### src/ucf_top.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "ucf_regs.svh"

module ucf_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic                     core_clk_i,
  input  wire logic                     srst_i,
  // Filling side.
  input  wire logic                     in_valid_i,
  input  wire logic [WIDTH-1:0]         in_data_i,
  output logic                          in_ready_o,
  // Draining side.
  output logic                          out_valid_o,
  output logic [WIDTH-1:0]              out_data_o,
  input  wire logic                     out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0]    count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [CW-1:0]               count;
  } ucf_fifo_s;

  ucf_fifo_s st_ff;
  ucf_fifo_s nxt_st;
  logic      push;
  logic      pop;

  // Depth must be a power of two so the pointers wrap by themselves.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("ucf_fifo depth must be a power of two of at least 2");
  end

  // Handshakes on both sides.
  assign in_ready_o  = (st_ff.count != CW'(DEPTH));
  assign out_valid_o = (st_ff.count != '0);
  assign out_data_o  = st_ff.mem[st_ff.rptr];
  assign count_o     = st_ff.count;
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Next state of pointers, count and storage.
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wptr] = in_data_i;
      nxt_st.wptr            = st_ff.wptr + AW'(1);
    end
    if (pop) begin
      nxt_st.rptr = st_ff.rptr + AW'(1);
    end
    nxt_st.count = st_ff.count + CW'(push) - CW'(pop);
  end

  // State register.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : ucf_fifo

module ucf_top
  import ucf_pkg::*;
#(
  parameter int BIT_CYCLES = `UCF_BIT_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // Avalon-MM slave.
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Serial line and flow control.
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             request_to_send_out_a_n_o,
  output logic             rx_level_reached_o
);
  localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
  localparam int          EW        = $bits(ucf_entry_s);

  // Parameters the logic cannot serve are refused.
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535 || FIFO_DEPTH != 16) begin : g_chk
    $error("ucf_top needs 4..65535 bit cycles and a 16 deep FIFO");
  end

  ucf_state_s st_ff;
  ucf_state_s nxt_st;
  logic       acc;
  logic       req;
  logic       wr_lane;
  logic       full_sel;
  logic       f_in_valid;
  logic       f_in_ready;
  logic       f_out_valid;
  logic       f_pop;
  ucf_entry_s f_top;
  logic [4:0] f_count;
  logic [2:0] flags_now;
  logic [2:0] flags_shown;
  logic [1:0] pmode;

  // Number of the last data bit for a length code.
  function automatic logic [2:0] last_bit(input logic [1:0] code);
    return {1'b1, code};
  endfunction : last_bit

  // Mask that keeps only the programmed data bits.
  function automatic logic [7:0] len_mask(input logic [1:0] code);
    return 8'hFF >> (2'h3 - code);
  endfunction : len_mask

  // Receive fill level reached for the selected depth and level code.
  function automatic logic lvl_hit(input logic [4:0] cnt, input logic big,
                                   input logic [1:0] code);
    logic [4:0] thr;
    case ({big, code})
      3'h0:    thr = 5'h01;
      3'h1:    thr = 5'h03;
      3'h2:    thr = 5'h06;
      3'h3:    thr = 5'h08;
      3'h4:    thr = 5'h01;
      3'h5:    thr = 5'h08;
      3'h6:    thr = 5'h0C;
      default: thr = 5'h10;
    endcase
    return cnt >= thr;
  endfunction : lvl_hit

  // Receive FIFO between the receiver hold stage and the bus.
  ucf_fifo #(
    .WIDTH (EW),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (f_in_valid),
    .in_data_i   (st_ff.hold),
    .in_ready_o  (f_in_ready),
    .out_valid_o (f_out_valid),
    .out_data_o  (f_top),
    .out_ready_i (f_pop),
    .count_o     (f_count)
  );

  // Bus decode and FIFO side terms.
  assign req         = avs_read_i | avs_write_i;
  assign acc         = req & ~st_ff.wait_req;
  assign wr_lane     = acc & avs_write_i & avs_byteenable_i[0];
  assign pmode       = st_ff.format_mode[`UCF_F_PMODE_HI:`UCF_F_PMODE_LO];
  assign full_sel    = st_ff.zero_mode[`UCF_F_DEPTH_SEL] ? (f_count >= `UCF_DEPTH_LARGE)
                                                         : (f_count >= `UCF_DEPTH_SMALL);
  assign f_in_valid  = st_ff.hold_v & ~full_sel;
  assign f_pop       = acc & avs_read_i & (avs_address_i == `UCF_OFF_RXDATA) & st_ff.rd_ok;
  assign flags_now   = f_out_valid ? {f_top.brk, f_top.parity_err, f_top.frame_err} : 3'h0;
  assign flags_shown = st_ff.format_mode[`UCF_F_ERRMODE] ? st_ff.accum : flags_now;

  // Outputs come straight from the state register.
  assign avs_readdata_o            = st_ff.rdata;
  assign avs_waitrequest_o         = st_ff.wait_req;
  assign txd_o                     = st_ff.txd;
  assign request_to_send_out_a_n_o = st_ff.rts_n;
  assign rx_level_reached_o        = st_ff.level;

  // Next state: bus slave, registers, receiver, flow control and transmitter.
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.valid_start = 1'b0;
    nxt_st.rx_s1       = rxd_i;
    nxt_st.rx_s2       = st_ff.rx_s1;
    // Waitrequest drops for one cycle after a request is first seen.
    if (req && st_ff.wait_req) begin
      nxt_st.wait_req = 1'b0;
      nxt_st.rd_ok    = f_out_valid;
      case (avs_address_i)
        `UCF_OFF_MODE:     nxt_st.rdata = {24'h0, st_ff.ptr_second ? st_ff.line_mode
                                                                   : st_ff.format_mode};
        `UCF_OFF_STATUS:   nxt_st.rdata = {24'h0, 1'b0, st_ff.overrun, flags_shown,
                                           st_ff.level, full_sel, f_out_valid};
        `UCF_OFF_RXDATA:   nxt_st.rdata = {24'h0, f_out_valid ? f_top.data : 8'h00};
        `UCF_OFF_OUTPORT:  nxt_st.rdata = {24'h0, st_ff.out_port};
        `UCF_OFF_ZEROMODE: nxt_st.rdata = {24'h0, st_ff.zero_mode};
        `UCF_OFF_TXDATA:   nxt_st.rdata = {31'h0, st_ff.tx_st != TX_IDLE};
        default:           nxt_st.rdata = 32'h0;
      endcase
    end else begin
      nxt_st.wait_req = 1'b1;
    end
    // Mode register access through the shared pointer.
    if (acc && avs_address_i == `UCF_OFF_MODE) begin
      if (wr_lane && !st_ff.ptr_second) begin
        nxt_st.format_mode = avs_writedata_i[7:0];
      end else if (wr_lane) begin
        nxt_st.line_mode = avs_writedata_i[7:0];
      end
      nxt_st.ptr_second = 1'b1;
    end
    if (wr_lane && avs_address_i == `UCF_OFF_OUTPORT) begin
      nxt_st.out_port = avs_writedata_i[7:0];
    end
    if (wr_lane && avs_address_i == `UCF_OFF_ZEROMODE) begin
      nxt_st.zero_mode = avs_writedata_i[7:0];
    end
    if (wr_lane && avs_address_i == `UCF_OFF_CMD) begin
      if (avs_writedata_i[7:0] == `UCF_CMD_SET_PTR) begin
        nxt_st.ptr_second = 1'b0;
      end
      if (avs_writedata_i[7:0] == `UCF_CMD_RST_ERR) begin
        nxt_st.accum   = 3'h0;
        nxt_st.overrun = 1'b0;
      end
    end
    // Block mode accumulates top-of-FIFO status; a new event beats the clear.
    nxt_st.accum = nxt_st.accum | flags_now;
    // Hold stage drains into the FIFO when the selected depth has room.
    if (f_in_valid && f_in_ready) begin
      nxt_st.hold_v = 1'b0;
    end
    // Receiver sequencer.
    nxt_st.rx_cnt = st_ff.rx_cnt + 16'h1;
    case (st_ff.rx_st)
      RX_IDLE: begin
        nxt_st.rx_cnt = 16'h0;
        if (!st_ff.rx_s2) begin
          nxt_st.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (st_ff.rx_cnt == HALF_LAST) begin
          nxt_st.rx_cnt = 16'h0;
          if (st_ff.rx_s2) begin
            nxt_st.rx_st = RX_IDLE;
          end else begin
            nxt_st.rx_st       = RX_DATA;
            nxt_st.rx_bit      = 3'h0;
            nxt_st.rx_shift    = 8'h00;
            nxt_st.valid_start = 1'b1;
            if (full_sel && st_ff.format_mode[`UCF_F_FLOW_EN]) begin
              nxt_st.flow_neg = 1'b1;
            end
            if (full_sel && st_ff.hold_v) begin
              nxt_st.overrun  = 1'b1;
              nxt_st.drop_cur = 1'b1;
            end
          end
        end
      end
      RX_DATA: begin
        if (st_ff.rx_cnt == BIT_LAST) begin
          nxt_st.rx_cnt                   = 16'h0;
          nxt_st.rx_shift[st_ff.rx_bit]   = st_ff.rx_s2;
          nxt_st.rx_bit                   = st_ff.rx_bit + 3'h1;
          if (st_ff.rx_bit == last_bit(st_ff.format_mode[`UCF_F_LEN_HI:`UCF_F_LEN_LO])) begin
            nxt_st.rx_st = (pmode == `UCF_PM_NONE) ? RX_STOP : RX_PAR;
          end
        end
      end
      RX_PAR: begin
        if (st_ff.rx_cnt == BIT_LAST) begin
          nxt_st.rx_cnt = 16'h0;
          nxt_st.rx_par = st_ff.rx_s2;
          nxt_st.rx_st  = RX_STOP;
        end
      end
      RX_STOP: begin
        if (st_ff.rx_cnt == BIT_LAST) begin
          nxt_st.rx_cnt = 16'h0;
          nxt_st.rx_st  = RX_IDLE;
          if (st_ff.drop_cur) begin
            nxt_st.drop_cur = 1'b0;
          end else begin
            nxt_st.hold_v          = 1'b1;
            nxt_st.hold.data       = st_ff.rx_shift;
            nxt_st.hold.frame_err  = ~st_ff.rx_s2;
            nxt_st.hold.brk        = ~st_ff.rx_s2 && st_ff.rx_shift == 8'h00 &&
                                     (pmode == `UCF_PM_NONE || !st_ff.rx_par);
            case (pmode)
              `UCF_PM_WITH:  nxt_st.hold.parity_err = (^st_ff.rx_shift) ^ st_ff.rx_par ^
                                                      st_ff.format_mode[`UCF_F_PTYPE];
              `UCF_PM_FORCE: nxt_st.hold.parity_err = st_ff.rx_par ^
                                                      st_ff.format_mode[`UCF_F_PTYPE];
              `UCF_PM_MDROP: nxt_st.hold.parity_err = st_ff.rx_par ^
                                                      st_ff.format_mode[`UCF_F_PTYPE];
              default:       nxt_st.hold.parity_err = 1'b0;
            endcase
          end
        end
      end
      default: nxt_st.rx_st = RX_IDLE;
    endcase
    // Negation ends as soon as a FIFO position is free; the port bit is untouched.
    if (!full_sel) begin
      nxt_st.flow_neg = 1'b0;
    end
    nxt_st.rts_n = ~(nxt_st.out_port[`UCF_F_RTS_BIT] & ~nxt_st.flow_neg);
    nxt_st.level = lvl_hit(f_count, st_ff.zero_mode[`UCF_F_DEPTH_SEL],
                           {st_ff.zero_mode[`UCF_F_LVL_HI],
                            st_ff.format_mode[`UCF_F_LVL_LO]});
    // Transmitter sequencer; a write while busy is ignored.
    nxt_st.tx_cnt = st_ff.tx_cnt + 16'h1;
    case (st_ff.tx_st)
      TX_IDLE: begin
        nxt_st.tx_cnt = 16'h0;
        if (wr_lane && avs_address_i == `UCF_OFF_TXDATA) begin
          nxt_st.tx_st    = TX_START;
          nxt_st.tx_bit   = 3'h0;
          nxt_st.tx_shift = avs_writedata_i[7:0] &
                            len_mask(st_ff.format_mode[`UCF_F_LEN_HI:`UCF_F_LEN_LO]);
          nxt_st.tx_par   = (pmode == `UCF_PM_WITH)
                          ? (^(avs_writedata_i[7:0] &
                               len_mask(st_ff.format_mode[`UCF_F_LEN_HI:`UCF_F_LEN_LO]))) ^
                            st_ff.format_mode[`UCF_F_PTYPE]
                          : st_ff.format_mode[`UCF_F_PTYPE];
        end
      end
      TX_START: begin
        if (st_ff.tx_cnt == BIT_LAST) begin
          nxt_st.tx_cnt = 16'h0;
          nxt_st.tx_st  = TX_DATA;
        end
      end
      TX_DATA: begin
        if (st_ff.tx_cnt == BIT_LAST) begin
          nxt_st.tx_cnt   = 16'h0;
          nxt_st.tx_shift = {1'b0, st_ff.tx_shift[7:1]};
          nxt_st.tx_bit   = st_ff.tx_bit + 3'h1;
          if (st_ff.tx_bit == last_bit(st_ff.format_mode[`UCF_F_LEN_HI:`UCF_F_LEN_LO])) begin
            nxt_st.tx_st = (pmode == `UCF_PM_NONE) ? TX_STOP : TX_PAR;
          end
        end
      end
      TX_PAR: begin
        if (st_ff.tx_cnt == BIT_LAST) begin
          nxt_st.tx_cnt = 16'h0;
          nxt_st.tx_st  = TX_STOP;
        end
      end
      TX_STOP: begin
        if (st_ff.tx_cnt == BIT_LAST) begin
          nxt_st.tx_cnt = 16'h0;
          nxt_st.tx_st  = TX_IDLE;
        end
      end
      default: nxt_st.tx_st = TX_IDLE;
    endcase
    // Line level follows the next transmitter state.
    case (nxt_st.tx_st)
      TX_START: nxt_st.txd = 1'b0;
      TX_DATA:  nxt_st.txd = nxt_st.tx_shift[0];
      TX_PAR:   nxt_st.txd = nxt_st.tx_par;
      default:  nxt_st.txd = 1'b1;
    endcase
  end

  // State register with reset values.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_ff          <= '0;
      st_ff.wait_req <= 1'b1;
      st_ff.rts_n    <= 1'b1;
      st_ff.rx_s1    <= 1'b1;
      st_ff.rx_s2    <= 1'b1;
      st_ff.txd      <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_mode_acc;
    acc && avs_address_i == `UCF_OFF_MODE;
  endsequence
  sequence s_set_ptr;
    wr_lane && avs_address_i == `UCF_OFF_CMD && avs_writedata_i[7:0] == `UCF_CMD_SET_PTR;
  endsequence

  a_bus_answer: assert property (req && st_ff.wait_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest did not drop for exactly one cycle");
  a_flow_negate: assert property (
    st_ff.valid_start && full_sel && st_ff.format_mode[7] && !f_pop
    |-> st_ff.flow_neg ##1 request_to_send_out_a_n_o)
    else $error("RTS not negated on start bit into full FIFO");
  a_overrun_flag: assert property (
    st_ff.rx_st == RX_START && nxt_st.valid_start && full_sel && st_ff.hold_v
    |=> st_ff.overrun && st_ff.drop_cur)
    else $error("overrun not flagged");
  a_port_kept: assert property ($rose(st_ff.flow_neg) |-> $stable(st_ff.out_port))
    else $error("port bit changed by flow control");
  a_rts_follow: assert property (
    st_ff.out_port[0] && !st_ff.flow_neg && !nxt_st.flow_neg
    && !(wr_lane && avs_address_i == `UCF_OFF_OUTPORT) |=> !request_to_send_out_a_n_o)
    else $error("RTS not asserted while port bit set");
  a_char_status: assert property (
    !st_ff.format_mode[5] && f_out_valid
    |-> flags_shown == {f_top.brk, f_top.parity_err, f_top.frame_err})
    else $error("character mode status not from FIFO top");
  a_block_status: assert property (
    st_ff.format_mode[5] && f_out_valid && f_top.frame_err |=> st_ff.accum[0])
    else $error("block mode lost a framing error");
  a_ptr_moves: assert property (s_mode_acc |=> st_ff.ptr_second)
    else $error("pointer not moved after format register access");
  a_ptr_reset: assert property (
    s_set_ptr and !(acc && avs_address_i == `UCF_OFF_MODE) |=> !st_ff.ptr_second)
    else $error("set pointer command ignored");
  a_no_parity: assert property (
    st_ff.tx_st == TX_DATA && nxt_st.tx_st == TX_STOP |-> pmode == `UCF_PM_NONE)
    else $error("parity bit skipped while parity enabled");
endmodule : ucf_top
`default_nettype wire

// ### tb/ucf_far_tx.sv
`timescale 1ns/10ps
`default_nettype none
// Remote transmitter on the receive line; it waits for clear-to-send before each character.
module ucf_far_tx #(
  parameter int BIT_CYCLES = 4
) (
  // Clock and flow control.
  input  wire logic core_clk_i,
  input  wire logic cts_n_i,
  // Serial line.
  output var logic  rxd_o
);
  logic ignore_cts;
  logic timed_out;
  // The line idles at mark level.
  initial begin
    rxd_o = 1'b1;
    ignore_cts = 1'b0;
    timed_out = 1'b0;
  end
  // Holds the line at one level for a whole bit time.
  task automatic put(input logic v);
    rxd_o <= v;
    repeat (BIT_CYCLES) @(posedge core_clk_i);
  endtask : put
  // Sends start, data LSB first, an optional parity or address bit, then stop and idle.
  task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic pb);
    int n;
    n = 0;
    while (cts_n_i !== 1'b0 && !ignore_cts && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 2000) timed_out = 1'b1;
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (pen) put(pb);
    put(1'b1);
    put(1'b1);
  endtask : send
endmodule : ucf_far_tx
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ucf_regs.svh"
module tb_top;
  localparam logic WR = 1'b1;
  localparam logic RD = 1'b0;
  logic        core_clk_i, srst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        rxd_i, txd_o, rts_n, lvl, pt, fl, cb, pe, xb;
  logic [4:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [1:0]  lc, pm;
  logic [7:0]  d;
  int          mismatches, check_count;
  // Device under test and the remote transmitter facing it.
  ucf_top #(.BIT_CYCLES(4), .FIFO_DEPTH(16)) i_dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(4'hF),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rxd_i(rxd_i), .txd_o(txd_o),
    .request_to_send_out_a_n_o(rts_n), .rx_level_reached_o(lvl));
  ucf_far_tx #(.BIT_CYCLES(4)) u_far (.core_clk_i(core_clk_i), .cts_n_i(rts_n), .rxd_o(rxd_i));
  // Free-running 10 MHz clock.
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // One Avalon-MM transfer held until waitrequest is sampled low; read data lands in q.
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= {24'h000000, wd};
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      complete_run();
    end
    @(posedge core_clk_i);
  endtask : acc
  // Main sequence: pointer, port bit, character formats, error modes, flow control.
  initial begin
    srst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    mismatches = 0;
    check_count = 0;
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    acc(RD, `UCF_OFF_MODE, 8'h00); chk(q, 32'h0);
    acc(WR, `UCF_OFF_CMD, `UCF_CMD_SET_PTR);
    acc(WR, `UCF_OFF_MODE, 8'h5A);
    acc(RD, `UCF_OFF_MODE, 8'h00); chk(q, 32'h0);
    acc(WR, `UCF_OFF_MODE, 8'h3C);
    acc(RD, `UCF_OFF_MODE, 8'h00); chk(q, 32'h3C);
    acc(WR, `UCF_OFF_CMD, `UCF_CMD_SET_PTR);
    acc(RD, `UCF_OFF_MODE, 8'h00); chk(q, 32'h5A);
    acc(RD, 5'h1C, 8'h00); chk(q, 32'h0);
    acc(WR, `UCF_OFF_OUTPORT, 8'h00);
    repeat (3) @(posedge core_clk_i); chk(rts_n, 1);
    acc(WR, `UCF_OFF_OUTPORT, 8'h01);
    repeat (3) @(posedge core_clk_i); chk(rts_n, 0);
    for (int m = 0; m < 32; m++) begin
      lc = m[1:0];
      pm = m[3:2];
      pt = m[4];
      fl = lc[0];
      d = 8'hA5 & (8'hFF >> (3 - lc));
      cb = (pm == `UCF_PM_WITH) ? (^d ^ pt) : pt;
      pe = (pm == `UCF_PM_NONE) ? 1'b0 : fl;
      acc(WR, `UCF_OFF_CMD, `UCF_CMD_SET_PTR);
      acc(WR, `UCF_OFF_MODE, {3'b000, pm, pt, lc});
      u_far.send(d, 5 + lc, pm != `UCF_PM_NONE, cb ^ fl);
      acc(RD, `UCF_OFF_STATUS, 8'h00); chk(q, {27'h0, pe, 4'h5});
      acc(RD, `UCF_OFF_RXDATA, 8'h00); chk(q, {24'h0, d});
      // Transmit the unmasked pattern and look at the line in the middle of every bit.
      acc(WR, `UCF_OFF_TXDATA, 8'hA5);
      repeat (2) @(posedge core_clk_i);
      for (int b = 0; b < 8 + lc; b++) begin
        if (b == 0) xb = 1'b0;
        else if (b <= 5 + lc) xb = d[b - 1];
        else if (b == 6 + lc && pm != `UCF_PM_NONE) xb = cb;
        else xb = 1'b1;
        chk(txd_o, xb);
        repeat (4) @(posedge core_clk_i);
      end
    end
    for (int e = 0; e < 2; e++) begin
      acc(WR, `UCF_OFF_CMD, `UCF_CMD_SET_PTR);
      acc(WR, `UCF_OFF_MODE, {2'b00, e[0], 5'h03});
      acc(WR, `UCF_OFF_CMD, `UCF_CMD_RST_ERR);
      u_far.send(8'h01, 8, 1'b1, 1'b0);
      u_far.send(8'h03, 8, 1'b1, 1'b0);
      acc(RD, `UCF_OFF_RXDATA, 8'h00); chk(q, 32'h01);
      acc(RD, `UCF_OFF_STATUS, 8'h00); chk(q[4], e[0]);
      acc(WR, `UCF_OFF_CMD, `UCF_CMD_RST_ERR);
      acc(RD, `UCF_OFF_STATUS, 8'h00); chk(q[4], 0);
      acc(RD, `UCF_OFF_RXDATA, 8'h00); chk(q, 32'h03);
    end
    acc(WR, `UCF_OFF_CMD, `UCF_CMD_SET_PTR);
    acc(WR, `UCF_OFF_MODE, 8'hD3);
    for (int i = 0; i < 10; i++) begin
      if (i == 9) u_far.ignore_cts = 1'b1;
      u_far.send(8'h10 + i[7:0], 8, 1'b0, 1'b0);
      if (i < 8) begin
        chk(lvl, i >= 2);
        chk(rts_n, 0);
        acc(RD, `UCF_OFF_STATUS, 8'h00); chk(q[1], i == 7);
      end
    end
    chk(rts_n, 1);
    acc(RD, `UCF_OFF_STATUS, 8'h00); chk(q[6], 1);
    acc(RD, `UCF_OFF_OUTPORT, 8'h00); chk(q, 32'h01);
    u_far.ignore_cts = 1'b0;
    for (int i = 0; i < 9; i++) begin
      acc(RD, `UCF_OFF_RXDATA, 8'h00); chk(q, 32'h10 + i);
      if (i == 0) begin
        repeat (3) @(posedge core_clk_i); chk(rts_n, 0);
      end
    end
    acc(RD, `UCF_OFF_STATUS, 8'h00); chk(q[0], 0);
    chk(u_far.timed_out, 0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
